// *** sic_defines.vh ***
/*
 * Constants shared by the two-wire master channel: frame layout, divider
 * limits, command word layout and reset levels.
 * Assumes it is included by bare name from the design files.
 */
`ifndef SIC_DEFINES_VH
`define SIC_DEFINES_VH

// ---------------------------------------------------------------
// frame layout
// ---------------------------------------------------------------
`define SIC_ACK_INDEX 4'h8
`define SIC_RISES_PER_FRAME 4'h9
`define SIC_SAMPLE_LAST 4'h7

// ---------------------------------------------------------------
// divider field of the data/divider register, bits 15..9
// ---------------------------------------------------------------
`define SIC_DIV_W 7
`define SIC_DIV_MIN 7'h01
`define SIC_END_WAIT 7'h04

// ---------------------------------------------------------------
// command word: bit 8 selects receive, bits 7..0 carry the byte
// ---------------------------------------------------------------
`define SIC_CMD_W 9
`define SIC_CMD_RX_POS 8
`define SIC_FIFO_DEPTH 32
`define SIC_FIFO_AW 5

// ---------------------------------------------------------------
// line levels and reset values
// ---------------------------------------------------------------
`define SIC_LINE_RELEASED 1'b1
`define SIC_ACK_LEVEL 1'b0
`define SIC_BYTE_RESET 8'hff
`define SIC_DRIVE_NONE 1'b0

`endif

// *** sic_insync.v ***
/*
 * Three-stage sampler for a line that comes from outside the clock domain.
 * Assumes the line idles high; a change counts once stages two and three agree.
 */
`timescale 1ns/10ps
`include "sic_defines.vh"

module sic_insync (
  // clock and reset
  input wire clk,
  input wire reset,
  // raw line
  input wire line_in,
  // filtered level and rising edge
  output reg level_r,
  output reg rise_r
);

  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge clk) begin
    if (reset) begin
      s1_r <= `SIC_LINE_RELEASED;
      s2_r <= `SIC_LINE_RELEASED;
      s3_r <= `SIC_LINE_RELEASED;
      level_r <= `SIC_LINE_RELEASED;
      rise_r <= 1'b0;
    end else begin
      s1_r <= line_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      rise_r <= 1'b0;
      // stage one is never looked at directly: metastability hazard
      if (s2_r == s3_r && s3_r != level_r) begin
        level_r <= s3_r;
        rise_r <= s3_r;
      end
    end
  end

endmodule // sic_insync

// *** sic_fifo.v ***
/*
 * Flip-flop FIFO with valid/ready on both sides and registered flags.
 * Assumes DEPTH is a power of two equal to 2**AW.
 */
`timescale 1ns/10ps
`include "sic_defines.vh"

module sic_fifo #(
  parameter WIDTH = `SIC_CMD_W,
  parameter DEPTH = `SIC_FIFO_DEPTH,
  parameter AW = `SIC_FIFO_AW
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // fill side
  input wire in_valid,
  output reg in_ready_r,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output reg out_valid_r,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_r;
  reg [AW-1:0] rd_r;
  reg [AW:0] cnt_r;
  reg [AW:0] cnt_nxt;
  wire push;
  wire pop;

  assign push = in_valid & in_ready_r;
  assign pop = out_ready & out_valid_r;
  assign out_data = mem_r[rd_r];

  always @* begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      wr_r <= {AW{1'b0}};
      rd_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      in_ready_r <= 1'b0;
      out_valid_r <= 1'b0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      // flags are registered so both ports come from flip-flops
      in_ready_r <= (cnt_nxt != DEPTH[AW:0]);
      out_valid_r <= (cnt_nxt != {(AW+1){1'b0}});
    end
  end

endmodule // sic_fifo

// *** sic_master.v ***
/*
 * Master-only two-wire serial channel: software makes start and stop with
 * the level bits while the start bit is low; queued command words then run
 * 9-clock frames (8 bits MSB first plus acknowledge) on open-drain pins.
 * Assumes a single master on the bus, pull-ups on both lines, and control
 * inputs synchronous to clk.
 */
`timescale 1ns/10ps
`include "sic_defines.vh"

// Contract
// - The channel is sole master only, with no slave mode, no arbitration and no clock-stretch wait.
// - Each frame has 8 data bits; an address byte holds 7 address bits over a direction bit.
// - The channel can drive an acknowledge to the slave and sample the slave's acknowledge.
// - With the serial output enable bit at 0 the channel drives no acknowledge on the last byte.
// - Only a transfer-end interrupt is given and software never selects buffer-empty mode.
// - Acknowledge error and overrun error flags are readable by software.
// - Address send, data send, data receive and stop generation are all supported.
// - An address frame follows the start condition and carries 7 address bits and 1 direction bit.
// - The data line is non-inverted and idles high.
// - Frames go MSB first without parity and with one extra bit for the acknowledge.
module sic_master #(
  parameter DEPTH = `SIC_FIFO_DEPTH,
  parameter AW = `SIC_FIFO_AW
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // channel control
  input wire channel_start_bit,
  input wire serial_output_enable_bit,
  input wire serial_output_level_bit,
  input wire clock_output_level_bit,
  input wire [`SIC_DIV_W-1:0] divider_field,
  // command stream: bit 8 high for receive, else byte to send
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [`SIC_CMD_W-1:0] cmd_data,
  // received byte
  output reg [7:0] rx_data_r,
  output reg rx_valid_r,
  input wire rx_read,
  // status
  output reg transfer_end_interrupt_r,
  output reg ack_error_flag_r,
  input wire ack_error_clear,
  output reg overrun_error_flag_r,
  input wire overrun_error_clear,
  output reg channel_busy_r,
  // clock pin
  input wire scl_in,
  output reg scl_out_r,
  output reg scl_oe_r,
  // data pin
  input wire sda_in,
  output reg sda_out_r,
  output reg sda_oe_r
);

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_LOAD = 3'h1;
  localparam ST_LOW = 3'h2;
  localparam ST_HIGH = 3'h3;
  localparam ST_END = 3'h4;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  reg [2:0] state_r;
  reg [`SIC_DIV_W-1:0] cnt_r;
  reg [3:0] bit_r;
  reg [3:0] rise_cnt_r;
  reg [7:0] shift_r;
  reg [7:0] capt_r;
  reg rxop_r;
  reg ack_r;
  reg scl_r;
  reg sda_r;
  wire fifo_valid;
  wire fifo_take;
  wire [`SIC_CMD_W-1:0] fifo_word;
  wire scl_lvl;
  wire scl_rise;
  wire sda_lvl;
  wire [`SIC_DIV_W-1:0] half_last;
  wire half_tick;
  wire end_done;
  wire rx_store;
  wire ack_fail;

  // clamp a zero divider to the least legal value
  function [`SIC_DIV_W-1:0] div_eff;
    input [`SIC_DIV_W-1:0] d;
    begin
      div_eff = (d < `SIC_DIV_MIN) ? `SIC_DIV_MIN : d;
    end
  endfunction

  // level to put on the data line for bit index b of a frame
  function bit_level;
    input rx;
    input [3:0] b;
    input [7:0] sh;
    begin
      if (b == `SIC_ACK_INDEX) begin
        bit_level = rx ? `SIC_ACK_LEVEL : `SIC_LINE_RELEASED;
      end else begin
        bit_level = rx ? `SIC_LINE_RELEASED : sh[7];
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // command queue and line samplers
  // ---------------------------------------------------------------
  sic_fifo #(
    .WIDTH(`SIC_CMD_W),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_cmd_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(cmd_valid),
    .in_ready_r(cmd_ready),
    .in_data(cmd_data),
    .out_valid_r(fifo_valid),
    .out_ready(fifo_take),
    .out_data(fifo_word)
  );

  sic_insync u_scl_sync (
    .clk(clk),
    .reset(reset),
    .line_in(scl_in),
    .level_r(scl_lvl),
    .rise_r(scl_rise)
  );

  sic_insync u_sda_sync (
    .clk(clk),
    .reset(reset),
    .line_in(sda_in),
    .level_r(sda_lvl),
    .rise_r()
  );

  // ---------------------------------------------------------------
  // frame timing
  // ---------------------------------------------------------------
  // a word is only taken once software has made the start condition
  assign fifo_take = (state_r == ST_IDLE) & channel_start_bit & fifo_valid;
  // half period is divider+1 clocks, so divider 1 gives clk/4
  assign half_last = div_eff(divider_field);
  assign half_tick = (cnt_r == half_last);
  // the wire's rises lag by the sampler depth, so wait a few clocks for them
  assign end_done = (rise_cnt_r == `SIC_RISES_PER_FRAME) | (cnt_r == `SIC_END_WAIT);
  assign rx_store = (state_r == ST_END) & end_done & rxop_r;
  // a slave that leaves the line high has refused the byte
  assign ack_fail = (state_r == ST_END) & end_done & ~rxop_r & ack_r;

  always @(posedge clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      cnt_r <= {`SIC_DIV_W{1'b0}};
      bit_r <= 4'h0;
      shift_r <= `SIC_BYTE_RESET;
      rxop_r <= 1'b0;
      scl_r <= `SIC_LINE_RELEASED;
      sda_r <= `SIC_LINE_RELEASED;
    end else if (!channel_start_bit) begin
      // dropping the start bit aborts the frame and hands the pins back
      state_r <= ST_IDLE;
      cnt_r <= {`SIC_DIV_W{1'b0}};
      scl_r <= clock_output_level_bit;
      sda_r <= serial_output_level_bit;
    end else begin
      case (state_r)
        ST_IDLE: begin
          cnt_r <= {`SIC_DIV_W{1'b0}};
          if (fifo_take) begin
            // one word per frame: address, data send or data receive
            shift_r <= fifo_word[7:0];
            rxop_r <= fifo_word[`SIC_CMD_RX_POS];
            bit_r <= 4'h0;
            scl_r <= 1'b0;
            state_r <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          // data moves one clock after the clock line fell
          sda_r <= bit_level(rxop_r, bit_r, shift_r);
          if (bit_r != `SIC_ACK_INDEX) begin
            shift_r <= {shift_r[6:0], 1'b1};
          end
          cnt_r <= cnt_r + 1'b1;
          state_r <= ST_LOW;
        end
        ST_LOW: begin
          if (half_tick) begin
            cnt_r <= {`SIC_DIV_W{1'b0}};
            scl_r <= 1'b1;
            state_r <= ST_HIGH;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ST_HIGH: begin
          // no wait on a held-low clock: stretching is not honoured
          if (half_tick) begin
            cnt_r <= {`SIC_DIV_W{1'b0}};
            scl_r <= 1'b0;
            if (bit_r == `SIC_ACK_INDEX) begin
              state_r <= ST_END;
            end else begin
              bit_r <= bit_r + 1'b1;
              state_r <= ST_LOAD;
            end
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ST_END: begin
          // clock stays low between frames; data released
          sda_r <= `SIC_LINE_RELEASED;
          cnt_r <= cnt_r + 1'b1;
          if (end_done) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // sampling on the rises seen on the wire
  // ---------------------------------------------------------------
  // both lines pass equal sampler depth, so the pair stays aligned
  always @(posedge clk) begin
    if (reset) begin
      rise_cnt_r <= 4'h0;
      capt_r <= `SIC_BYTE_RESET;
      ack_r <= 1'b0;
    end else if (fifo_take) begin
      rise_cnt_r <= 4'h0;
    end else if (scl_rise && scl_lvl && state_r != ST_IDLE) begin
      if (rise_cnt_r <= `SIC_SAMPLE_LAST) begin
        capt_r <= {capt_r[6:0], sda_lvl};
        rise_cnt_r <= rise_cnt_r + 1'b1;
      end else if (rise_cnt_r == `SIC_ACK_INDEX) begin
        ack_r <= sda_lvl;
        rise_cnt_r <= rise_cnt_r + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // status, interrupt and receive holding register
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      transfer_end_interrupt_r <= 1'b0;
      ack_error_flag_r <= 1'b0;
      overrun_error_flag_r <= 1'b0;
      rx_data_r <= 8'h00;
      rx_valid_r <= 1'b0;
      channel_busy_r <= 1'b0;
    end else begin
      channel_busy_r <= (state_r != ST_IDLE) | fifo_take;
      // one pulse per finished frame, never a buffer-empty event
      transfer_end_interrupt_r <= (state_r == ST_END) & end_done & channel_start_bit;
      // set wins over a clear in the same clock
      if (ack_fail && channel_start_bit) begin
        ack_error_flag_r <= 1'b1;
      end else if (ack_error_clear) begin
        ack_error_flag_r <= 1'b0;
      end
      if (rx_store && channel_start_bit && rx_valid_r && !rx_read) begin
        overrun_error_flag_r <= 1'b1;
      end else if (overrun_error_clear) begin
        overrun_error_flag_r <= 1'b0;
      end
      if (rx_store && channel_start_bit) begin
        rx_data_r <= capt_r;
        rx_valid_r <= 1'b1;
      end else if (rx_read) begin
        rx_valid_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // open-drain pins
  // ---------------------------------------------------------------
  // clearing the output enable releases data, so no acknowledge goes out
  always @(posedge clk) begin
    if (reset) begin
      scl_out_r <= 1'b0;
      sda_out_r <= 1'b0;
      scl_oe_r <= `SIC_DRIVE_NONE;
      sda_oe_r <= `SIC_DRIVE_NONE;
    end else begin
      scl_out_r <= 1'b0;
      sda_out_r <= 1'b0;
      scl_oe_r <= ~scl_r;
      sda_oe_r <= ~sda_r & serial_output_enable_bit;
    end
  end

endmodule // sic_master

// *** sic_master_asserts.sv ***
/*
 * Port-level checker for sic_master, bound to every instance.
 * Assumes clk rising, reset synchronous active high.
 */
`timescale 1ns/10ps
module sic_master_asserts (
  // clock and reset
  input wire clk,
  input wire reset,
  // control
  input wire channel_start_bit,
  input wire serial_output_enable_bit,
  input wire serial_output_level_bit,
  input wire clock_output_level_bit,
  input wire ack_error_clear,
  // status
  input wire transfer_end_interrupt_r,
  input wire ack_error_flag_r,
  input wire channel_busy_r,
  // pins
  input wire scl_out_r,
  input wire scl_oe_r,
  input wire sda_out_r,
  input wire sda_oe_r
);
  // ----------------
  // clock releases in a frame
  // ----------------
  reg [3:0] rel_r;
  reg oe_d_r;
  always @(posedge clk) begin
    oe_d_r <= scl_oe_r;
    if (reset || transfer_end_interrupt_r || !channel_start_bit) rel_r <= 4'h0;
    else if (oe_d_r && !scl_oe_r) rel_r <= rel_r + 4'h1;
  end
  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // level inputs held over three cycles so any latency up to two cycles is covered
  sequence s_manual;
    (!channel_start_bit && $stable(serial_output_level_bit)
      && $stable(clock_output_level_bit) && $stable(serial_output_enable_bit)) [*3];
  endsequence
  sequence s_no_out;
    !serial_output_enable_bit [*3];
  endsequence
  property p_pins_low;
    !scl_out_r && !sda_out_r;
  endproperty
  property p_reset_idle;
    $fell(reset) |-> !scl_oe_r && !sda_oe_r && !ack_error_flag_r && !channel_busy_r;
  endproperty
  property p_manual;
    s_manual |-> scl_oe_r == !clock_output_level_bit
      && sda_oe_r == (!serial_output_level_bit && serial_output_enable_bit);
  endproperty
  property p_no_drive;
    s_no_out |-> !sda_oe_r;
  endproperty
  property p_irq_pulse;
    transfer_end_interrupt_r |=> !transfer_end_interrupt_r;
  endproperty
  property p_nine;
    transfer_end_interrupt_r |-> rel_r == 4'h9;
  endproperty
  property p_ack_sticky;
    ack_error_flag_r && !ack_error_clear |=> ack_error_flag_r;
  endproperty
  property p_sda_moves;
    channel_start_bit && $past(channel_start_bit) && channel_busy_r && $changed(sda_oe_r)
      |-> scl_oe_r && $past(scl_oe_r);
  endproperty
  a_pins_low: assert property (p_pins_low) else $error("pin driven high");
  a_reset_idle: assert property (p_reset_idle) else $error("not idle");
  a_manual: assert property (p_manual) else $error("level bits");
  a_no_drive: assert property (p_no_drive) else $error("data driven");
  a_irq_pulse: assert property (p_irq_pulse) else $error("long irq");
  a_nine: assert property (p_nine) else $error("clock count");
  a_ack_sticky: assert property (p_ack_sticky) else $error("ack flag lost");
  a_sda_moves: assert property (p_sda_moves) else $error("data moved");
endmodule // sic_master_asserts

bind sic_master sic_master_asserts chk_u (
  .clk(clk),
  .reset(reset),
  .channel_start_bit(channel_start_bit),
  .serial_output_enable_bit(serial_output_enable_bit),
  .serial_output_level_bit(serial_output_level_bit),
  .clock_output_level_bit(clock_output_level_bit),
  .ack_error_clear(ack_error_clear),
  .transfer_end_interrupt_r(transfer_end_interrupt_r),
  .ack_error_flag_r(ack_error_flag_r),
  .channel_busy_r(channel_busy_r),
  .scl_out_r(scl_out_r),
  .scl_oe_r(scl_oe_r),
  .sda_out_r(sda_out_r),
  .sda_oe_r(sda_oe_r)
);

// *** sic_slave_model.sv ***
/*
 * Two-wire slave stand-in: acks written bytes, sends tx_byte when read.
 * Assumes open-drain lines with pull-ups resolved by the bench.
 */
`timescale 1ns/10ps
module sic_slave_model (
  // bus lines
  input wire scl,
  input wire sda,
  output reg sda_oe_r,
  // test control
  input wire rd,
  input wire nack,
  input wire [7:0] tx_byte,
  // observed frame
  output reg [7:0] got_r,
  output reg got_ack_r,
  output reg done_r
);
  reg [7:0] sh_r;
  integer n;
  initial begin
    sda_oe_r = 1'b0;
    n = 0;
    done_r = 1'b0;
    got_r = 8'h00;
    got_ack_r = 1'b1;
    sh_r = 8'h00;
  end
  // start condition realigns the bit count
  always @(negedge sda) if (scl) n = 0;
  // eight bits msb first, then the acknowledge bit
  always @(posedge scl) begin
    if (n < 8) sh_r = {sh_r[6:0], sda};
    else begin
      got_r = sh_r;
      got_ack_r = sda;
      done_r = ~done_r;
    end
    n = (n + 1) % 9;
  end
  // a master nack ends a read, so the line is let go
  always @(negedge scl) begin
    if (n == 8) sda_oe_r = !rd && !nack;
    else sda_oe_r = rd && !(n == 0 && got_ack_r) && !tx_byte[7 - n];
  end
  always @(rd or tx_byte) if (!scl && n == 0) sda_oe_r = rd && !tx_byte[7];
endmodule // sic_slave_model

// *** simple_i2c_master_address_phase_tb_top.sv ***
/*
 * Self-checking bench for sic_master with a slave model on the lines.
 * Assumes sic_master, sic_slave_model and the checker compile first.
 */
`timescale 1ns/10ps
module simple_i2c_master_address_phase_tb_top;
  // ----------------
  // stimulus and lines
  // ----------------
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg start_b = 1'b0;
  reg oen = 1'b1;
  reg lvl = 1'b1;
  reg clvl = 1'b1;
  // divider 3 gives an 8-clock link period; the rate scales with clk
  reg [6:0] div = 7'h03;
  reg cmd_valid = 1'b0;
  reg [8:0] cmd_data = 9'h000;
  reg rx_read = 1'b0;
  reg ack_clr = 1'b0;
  reg ovr_clr = 1'b0;
  reg rd = 1'b0;
  reg nack = 1'b0;
  reg [7:0] txb = 8'h00;
  reg [7:0] exp_q[$];
  reg [31:0] seed = 32'h502685e5;
  reg [7:0] r;
  integer fail_count = 0;
  integer tests_run = 0;
  integer irq_n = 0;
  integer nfr = 0;
  wire cmd_ready, rx_valid, irq, ackf, ovrf, busy, scl_o, scl_oe, sda_o, sda_oe, s_oe;
  wire got_ack, got_t;
  wire [7:0] rx_data;
  wire [7:0] got;
  // pull-ups on open-drain pins: a line is high unless pulled low
  wire scl_w = !(scl_oe && !scl_o);
  wire sda_w = !((sda_oe && !sda_o) || s_oe);
  always #20 clk = ~clk;
  always @(posedge clk) if (irq === 1'b1) irq_n <= irq_n + 1;
  sic_master #(.DEPTH(32), .AW(5)) dut_u (.clk(clk), .reset(reset),
    .channel_start_bit(start_b), .serial_output_enable_bit(oen),
    .serial_output_level_bit(lvl), .clock_output_level_bit(clvl), .divider_field(div),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data),
    .rx_data_r(rx_data), .rx_valid_r(rx_valid), .rx_read(rx_read),
    .transfer_end_interrupt_r(irq), .ack_error_flag_r(ackf), .ack_error_clear(ack_clr),
    .overrun_error_flag_r(ovrf), .overrun_error_clear(ovr_clr), .channel_busy_r(busy),
    .scl_in(scl_w), .scl_out_r(scl_o), .scl_oe_r(scl_oe),
    .sda_in(sda_w), .sda_out_r(sda_o), .sda_oe_r(sda_oe));
  sic_slave_model slv_u (.scl(scl_w), .sda(sda_w), .sda_oe_r(s_oe), .rd(rd), .nack(nack),
    .tx_byte(txb), .got_r(got), .got_ack_r(got_ack), .done_r(got_t));
  // ----------------
  // tasks
  // ----------------
  task check(input string what, input [8:0] seen, input [8:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("Error %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d errors %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task push(input [8:0] w);
    begin
      cmd_data = w;
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1) @(posedge clk) #1;
      @(posedge clk) #1;
      cmd_valid = 1'b0;
      exp_q.push_back(w[8] ? txb : w[7:0]);
      // let an edge pass so the next call never re-raises valid in this step
      @(posedge clk) #1;
    end
  endtask
  task frame(input [8:0] w);
    begin
      rd = w[8];
      push(w);
      while (irq !== 1'b1) @(posedge clk) #1;
      @(posedge clk) #1;
      nfr = nfr + 1;
    end
  endtask
  // 0: ack clear, 1: overrun clear, other: read strobe
  task pulse(input integer which);
    begin
      if (which == 0) ack_clr = 1'b1;
      else if (which == 1) ovr_clr = 1'b1;
      else rx_read = 1'b1;
      @(posedge clk) #1;
      ack_clr = 1'b0;
      ovr_clr = 1'b0;
      rx_read = 1'b0;
      @(posedge clk) #1;
    end
  endtask
  // ----------------
  // checking and sequence
  // ----------------
  initial begin
    #1;
    forever begin
      @(got_t);
      if (exp_q.size() == 0) check("extra frame", 9'h001, 9'h000);
      else check("slave byte", {1'b0, got}, {1'b0, exp_q.pop_front()});
    end
  end
  initial begin
    #(40 * 20000);
    fail_count = fail_count + 1;
    stop_test;
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    repeat (4) @(posedge clk) #1;
    // software start: data falls while clock is released
    lvl = 1'b0;
    repeat (4) @(posedge clk) #1;
    check("start lines", {7'h00, scl_w, sda_w}, 9'h002);
    start_b = 1'b1;
    repeat (4) begin
      r = $random(seed);
      frame({1'b0, r});
    end
    check("ack flag", {8'h00, ackf}, 9'h000);
    check("busy idle", {8'h00, busy}, 9'h000);
    nack = 1'b1;
    frame({1'b0, r});
    nack = 1'b0;
    check("ack flag", {8'h00, ackf}, 9'h001);
    pulse(0);
    check("ack clear", {8'h00, ackf}, 9'h000);
    txb = $random(seed);
    frame(9'h100);
    check("rx byte", {1'b0, rx_data}, {1'b0, txb});
    check("master ack", {8'h00, got_ack}, 9'h000);
    frame(9'h100);
    check("overrun", {8'h00, ovrf}, 9'h001);
    pulse(1);
    check("overrun clear", {8'h00, ovrf}, 9'h000);
    pulse(2);
    check("rx empty", {8'h00, rx_valid}, 9'h000);
    oen = 1'b0;
    frame(9'h100);
    oen = 1'b1;
    rd = 1'b0;
    check("last ack", {8'h00, got_ack}, 9'h001);
    check("irqs", irq_n[8:0], nfr[8:0]);
    // hold the clock low, queue a full buffer, then let it drain
    clvl = 1'b0;
    @(posedge clk) #1;
    start_b = 1'b0;
    repeat (32) begin
      r = $random(seed);
      push({1'b0, r});
    end
    @(posedge clk) #1;
    check("buffer full", {8'h00, cmd_ready}, 9'h000);
    start_b = 1'b1;
    repeat (4) @(posedge clk) #1;
    check("busy run", {8'h00, busy}, 9'h001);
    while (exp_q.size() != 0) @(posedge clk) #1;
    repeat (20) @(posedge clk) #1;
    check("irqs", irq_n[8:0], nfr[8:0] + 9'h020);
    // software stop: clock up, then data up
    clvl = 1'b0;
    @(posedge clk) #1;
    start_b = 1'b0;
    repeat (4) @(posedge clk) #1;
    clvl = 1'b1;
    repeat (4) @(posedge clk) #1;
    lvl = 1'b1;
    repeat (4) @(posedge clk) #1;
    check("idle lines", {7'h00, scl_w, sda_w}, 9'h003);
    stop_test;
  end
endmodule // simple_i2c_master_address_phase_tb_top
